// *** sbo_agent_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********************
// external agent model
// ********************
module sbo_agent_model (
   input wire logic clk_sys,
   input wire logic ok_n,
   input wire logic want_bus,
   input wire logic go,
   input wire logic [2:0] burst,
   input wire logic processor_owns_bus_n,
   output logic agent_accept_n,
   output logic agent_bus_request_n,
   output logic agent_word_valid_n,
   output logic [31:0] agent_ad,
   output logic [4:0] agent_cmd
);
   logic drive;
   logic [2:0] left;
   initial begin
      {agent_accept_n, agent_bus_request_n, agent_word_valid_n} = 3'h7;
      {drive, left, agent_ad, agent_cmd} = '0;
   end
   always @(posedge clk_sys) begin
      agent_accept_n <= ok_n;
      agent_bus_request_n <= !want_bus;
      drive <= processor_owns_bus_n;
      agent_word_valid_n <= 1'h1;
      agent_ad <= drive ? agent_ad : ~agent_ad;
      if (drive && processor_owns_bus_n && left != 3'h0) begin
         agent_word_valid_n <= 1'h0;
         agent_ad <= 32'h1000_0000 + left;
         agent_cmd <= {1'h1, left == 3'h1, 3'h0};
         left <= left - 3'h1;
      end
      if (go) begin
         left <= burst;
      end
   end
endmodule // sbo_agent_model
`default_nettype wire

// *** sbo_arbiter.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbo_defines.vh"

// Summary of operation
// - on release negate ownership, float one cycle
// - on return, float then own and drive
// - valid strobe repeats the held word until it is accepted or the bus is released
// - command issued after two consecutive accept cycles
// - agent returns read data at any pace
// - accept high after low kills command; retry
// - killed read: release next cycle, reclaim later
// - grant after at most one more request
// - reclaim five cycles after request negated
// - pending read releases bus until last word
// - request held through last word keeps agent master
// - slave state never stalls; a word arriving at a full buffer is lost unless one is read that cycle
// - any reset makes processor bus master
// - owner drives always, floats only at handover
// - outputs launched and inputs captured on clk edge
// - command top bit marks address or data cycle
// - after read issue move to slave unprompted
module sbo_arbiter #(
   parameter AD_WIDTH = `SBO_AD_WIDTH,
   parameter CMD_WIDTH = `SBO_CMD_WIDTH
) (
   input wire clk_sys,
   input wire reset_n,
   input wire power_on_reset_n,
   // shared buses as three signals each
   input wire [AD_WIDTH-1:0] shared_addr_data_bus_in,
   output reg [AD_WIDTH-1:0] shared_addr_data_bus_out,
   output reg shared_addr_data_bus_oe,
   input wire [CMD_WIDTH-1:0] shared_command_bus_in,
   output reg [CMD_WIDTH-1:0] shared_command_bus_out,
   output reg shared_command_bus_oe,
   output reg processor_owns_bus_n,
   output reg processor_word_valid_n,
   input wire agent_word_valid_n,
   input wire agent_accept_n,
   input wire agent_bus_request_n,
   // core side request stream
   input wire req_valid,
   output wire req_ready,
   input wire [AD_WIDTH-1:0] req_addr_data,
   input wire [CMD_WIDTH-1:0] req_command,
   output reg req_issued,
   output reg req_killed,
   // received words from the agent
   output wire rx_valid,
   input wire rx_ready,
   output wire [AD_WIDTH-1:0] rx_addr_data,
   output wire [CMD_WIDTH-1:0] rx_command,
   output reg rx_overflow,
   output wire read_pending
);

   // ************************************************************
   // input capture
   // ************************************************************
   reg [AD_WIDTH-1:0] in_ad;
   reg [CMD_WIDTH-1:0] in_cmd;
   reg in_valid;
   reg in_req;
   reg acc_now;
   reg acc_prev;
   wire any_reset = ~reset_n | ~power_on_reset_n;

   always @(posedge clk_sys) begin
      if (any_reset) begin
         in_ad <= `SBO_RST_AD;
         in_cmd <= `SBO_RST_CMD;
         in_valid <= 1'b0;
         in_req <= 1'b0;
         acc_now <= 1'b0;
         acc_prev <= 1'b0;
      end else begin
         in_ad <= shared_addr_data_bus_in;
         in_cmd <= shared_command_bus_in;
         in_valid <= ~agent_word_valid_n;
         in_req <= ~agent_bus_request_n;
         acc_now <= ~agent_accept_n;
         acc_prev <= acc_now;
      end
   end

   function is_addr_cycle;
      input [CMD_WIDTH-1:0] cmd;
      begin
         is_addr_cycle = (cmd[`SBO_CMD_TYPE_BIT] == `SBO_CMD_ADDR_CYCLE);
      end
   endfunction

   function is_read_cmd;
      input [CMD_WIDTH-1:0] cmd;
      begin
         is_read_cmd = is_addr_cycle(cmd) &&
            (cmd[3:0] == `SBO_CMD_READ);
      end
   endfunction

   // ************************************************************
   // arbitration state machine
   // ************************************************************
   reg [2:0] state;
   reg [2:0] next_state;
   reg [1:0] wait_cnt;
   reg [1:0] next_wait_cnt;
   reg pend_read;
   reg sent_once; // a request was offered since agent asked
   reg killed_read;

   wire own_bus = (state == `SBO_ST_MASTER);
   // accepted on two consecutive cycles of the accept line
   wire issue_now = own_bus & ~processor_word_valid_n &
      acc_now & acc_prev;
   wire kill_now = own_bus & ~processor_word_valid_n &
      acc_prev & ~acc_now;
   wire last_word = in_valid &
      ~is_addr_cycle(in_cmd) & in_cmd[`SBO_ID_LAST_BIT];
   wire issued_read = issue_now & is_read_cmd(shared_command_bus_out);
   // grant once one request went out, or accept is withheld
   wire grant = in_req & (sent_once | ~acc_now);

   always @* begin
      next_state = state;
      next_wait_cnt = wait_cnt;
      case (state)
         `SBO_ST_MASTER: begin
            if (grant | issued_read | killed_read) begin
               next_state = `SBO_ST_FLOAT_OUT;
            end
         end
         `SBO_ST_FLOAT_OUT: begin
            next_state = `SBO_ST_SLAVE;
         end
         `SBO_ST_SLAVE: begin
            // reclaim when neither read nor request holds us
            if (~in_req & ~pend_read) begin
               next_state = `SBO_ST_FLOAT_IN;
               next_wait_cnt = 2'h1;
            end
         end
         `SBO_ST_FLOAT_IN: begin
            if (in_req) begin
               next_state = `SBO_ST_SLAVE;
            end else if (wait_cnt == 2'h0) begin
               next_state = `SBO_ST_RECLAIM;
            end else begin
               next_wait_cnt = wait_cnt - 2'h1;
            end
         end
         `SBO_ST_RECLAIM: begin
            next_state = `SBO_ST_MASTER;
         end
         default: begin
            next_state = `SBO_ST_MASTER;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (any_reset) begin
         state <= `SBO_ST_MASTER;
         wait_cnt <= 2'h0;
         pend_read <= 1'b0;
         sent_once <= 1'b0;
         killed_read <= 1'b0;
      end else begin
         state <= next_state;
         wait_cnt <= next_wait_cnt;
         // killed read hands the bus over one cycle later
         killed_read <= kill_now &
            is_read_cmd(shared_command_bus_out);
         if (issued_read) begin
            pend_read <= 1'b1;
         end else if (last_word & (state == `SBO_ST_SLAVE)) begin
            pend_read <= 1'b0;
         end
         if (~in_req) begin
            sent_once <= 1'b0;
         end else if (own_bus & ~processor_word_valid_n) begin
            sent_once <= 1'b1;
         end
      end
   end

   // ************************************************************
   // bus drive
   // ************************************************************
   // a killed read must not re-offer before release
   assign req_ready = own_bus & (next_state == `SBO_ST_MASTER) &
      (processor_word_valid_n | issue_now) & ~pend_read;

   always @(posedge clk_sys) begin
      if (any_reset) begin
         processor_owns_bus_n <= 1'b0;
         shared_addr_data_bus_oe <= 1'b1;
         shared_command_bus_oe <= 1'b1;
         shared_addr_data_bus_out <= `SBO_RST_AD;
         shared_command_bus_out <= `SBO_RST_CMD;
         processor_word_valid_n <= 1'b1;
         req_issued <= 1'b0;
         req_killed <= 1'b0;
      end else begin
         // drive only while master
         processor_owns_bus_n <= ~((next_state == `SBO_ST_MASTER));
         shared_addr_data_bus_oe <= (next_state == `SBO_ST_MASTER);
         shared_command_bus_oe <= (next_state == `SBO_ST_MASTER);
         req_issued <= issue_now;
         req_killed <= kill_now;
         if (next_state != `SBO_ST_MASTER) begin
            processor_word_valid_n <= 1'b1;
         end else if (req_valid & req_ready) begin
            shared_addr_data_bus_out <= req_addr_data;
            shared_command_bus_out <= req_command;
            processor_word_valid_n <= 1'b0;
         end else if (issue_now) begin
            processor_word_valid_n <= 1'b1;
         end
         // otherwise the held word is reissued until accepted
      end
   end

   // ************************************************************
   // two-entry receive buffer
   // ************************************************************
   localparam W = AD_WIDTH + CMD_WIDTH;
   reg [W-1:0] buf_mem [0:1];
   reg wr_ptr;
   reg rd_ptr;
   reg [1:0] count;
   wire push = in_valid & (state == `SBO_ST_SLAVE);
   wire pop = rx_valid & rx_ready;
   wire full = (count == 2'h2);

   assign rx_valid = (count != 2'h0);
   assign {rx_addr_data, rx_command} = buf_mem[rd_ptr];
   assign read_pending = pend_read;

   always @(posedge clk_sys) begin
      if (any_reset) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
         rx_overflow <= 1'b0;
         buf_mem[0] <= {W{1'b0}};
         buf_mem[1] <= {W{1'b0}};
      end else begin
         // agent cannot be stalled; a full buffer flags loss
         rx_overflow <= push & full & ~pop;
         if (push & (~full | pop)) begin
            buf_mem[wr_ptr] <= {in_ad, in_cmd};
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         case ({push & (~full | pop), pop})
            2'b10: count <= count + 2'h1;
            2'b01: count <= count - 2'h1;
            default: count <= count;
         endcase
      end
   end

endmodule // sbo_arbiter
`default_nettype wire

// *** sbo_arbiter_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***************************
// ownership handshake checks
// ***************************
module sbo_arbiter_properties (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic power_on_reset_n,
   input wire logic shared_addr_data_bus_oe,
   input wire logic shared_command_bus_oe,
   input wire logic processor_owns_bus_n,
   input wire logic processor_word_valid_n,
   input wire logic agent_accept_n,
   input wire logic agent_bus_request_n,
   input wire logic req_ready,
   input wire logic req_issued,
   input wire logic read_pending
);
   logic ok_prev;
   logic ok_run;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n || !power_on_reset_n);
   always @(posedge clk_sys) begin
      ok_prev <= !agent_accept_n;
   end
   assign ok_run = ok_prev && !agent_accept_n;
   sequence s_float;
      processor_owns_bus_n && !shared_addr_data_bus_oe;
   endsequence
   sequence s_granted;
      processor_owns_bus_n;
   endsequence
   chk_reset_owner: assert property ($past(!reset_n || !power_on_reset_n)
      |-> !processor_owns_bus_n && shared_addr_data_bus_oe)
      else $error("processor not owner after reset");
   chk_slave_floats: assert property (processor_owns_bus_n |-> s_float)
      else $error("bus driven while slave");
   chk_buses_paired: assert property (
      shared_addr_data_bus_oe == shared_command_bus_oe)
      else $error("bus enables differ");
   chk_float_before_own: assert property ($fell(processor_owns_bus_n)
      |-> $past(!shared_addr_data_bus_oe))
      else $error("no float cycle before reclaim");
   chk_reclaim_delay: assert property ($rose(agent_bus_request_n)
      && processor_owns_bus_n && !read_pending
      |-> s_float ##[1:5] !processor_owns_bus_n)
      else $error("bus not reclaimed after request drop");
   chk_valid_owned: assert property (!processor_word_valid_n
      |-> !processor_owns_bus_n && shared_addr_data_bus_oe)
      else $error("word offered without ownership");
   chk_issue_after_ok: assert property (req_issued
      |-> $past(ok_run, 1) || $past(ok_run, 2) || $past(ok_run, 3))
      else $error("issue without two accept samples");
   chk_busy_refused: assert property (s_granted or read_pending
      |-> !req_ready)
      else $error("request taken while slave");
   chk_grant_release: assert property (
      (!agent_bus_request_n && agent_accept_n) [*6] |-> s_granted)
      else $error("bus not granted to agent");
endmodule // sbo_arbiter_properties
bind sbo_arbiter sbo_arbiter_properties chk (.*);
`default_nettype wire

// *** sbo_defines.vh ***
`ifndef SBO_DEFINES_VH
`define SBO_DEFINES_VH

// bus widths
`define SBO_AD_WIDTH 32
`define SBO_CMD_WIDTH 5

// top bit of the command bus: cycle type
`define SBO_CMD_TYPE_BIT 4
`define SBO_CMD_ADDR_CYCLE 1'h0
`define SBO_CMD_DATA_CYCLE 1'h1

// data identifier bit marking the last word of a response
`define SBO_ID_LAST_BIT 3

// command codes distinguishing read from write (low four bits)
`define SBO_CMD_READ 4'h0
`define SBO_CMD_WRITE 4'h8

// arbitration states
`define SBO_ST_MASTER 3'h0
`define SBO_ST_FLOAT_OUT 3'h1
`define SBO_ST_SLAVE 3'h2
`define SBO_ST_FLOAT_IN 3'h3
`define SBO_ST_RECLAIM 3'h4

// handover delays in cycles
`define SBO_ACCEPT_RUN 2
`define SBO_RECLAIM_DELAY 2

// reset values
`define SBO_RST_AD 32'h0000_0000
`define SBO_RST_CMD 5'h00

`endif

// *** tb_sbo_arbiter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sbo_defines.vh"
module tb_sbo_arbiter;
   logic clk_sys, reset_n, power_on_reset_n, req_valid, rx_ready;
   logic ok_n, want_bus, go, rand_ok;
   logic [2:0] burst;
   logic [31:0] req_addr_data, shared_addr_data_bus_in;
   logic [31:0] shared_addr_data_bus_out, agent_ad, rx_addr_data;
   logic [4:0] req_command, shared_command_bus_in, shared_command_bus_out;
   logic [4:0] agent_cmd, rx_command;
   logic shared_addr_data_bus_oe, shared_command_bus_oe;
   logic processor_owns_bus_n, processor_word_valid_n, agent_word_valid_n;
   logic agent_accept_n, agent_bus_request_n, req_ready, req_issued;
   logic req_killed, rx_valid, rx_overflow, read_pending;
   int fails = 0, samples_checked = 0, issues = 0;
   assign shared_addr_data_bus_in =
      shared_addr_data_bus_oe ? shared_addr_data_bus_out : agent_ad;
   assign shared_command_bus_in =
      shared_command_bus_oe ? shared_command_bus_out : agent_cmd;
   sbo_arbiter dut (.*);
   sbo_agent_model agent (.*);
   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) begin
      if (rand_ok) ok_n = ($urandom % 3) == 0;
   end
   always @(posedge clk_sys) begin
      if (req_issued === 1'h1) issues++;
   end
   // ***************
   // helper tasks
   // ***************
   function automatic logic [31:0] exp_word(input int k);
      return 32'h1000_0000 + k;
   endfunction
   task automatic check(input logic [31:0] seen, exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checked %0d, failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // a killed write stays offered and is reissued by the design itself
   task automatic send(input logic [31:0] w, input logic [4:0] c);
      req_valid = 1'h1;
      req_addr_data = w;
      req_command = c;
      while (req_ready !== 1'h1) @(negedge clk_sys);
      @(negedge clk_sys);
      req_valid = 1'h0;
      check(shared_addr_data_bus_out, w, "bus word");
      check(shared_command_bus_out, c, "bus command");
      while (req_issued !== 1'h1) begin
         if (req_killed === 1'h1)
            check(processor_word_valid_n, 1'h0, "retry held");
         @(negedge clk_sys);
      end
      @(negedge clk_sys);
   endtask
   task automatic drain(input int n);
      rx_ready = 1'h1;
      for (int k = n; k > 0; k--) begin
         while (rx_valid !== 1'h1) @(negedge clk_sys);
         check(rx_addr_data, exp_word(k), "rx word");
         check(rx_command, {1'h1, k == 1, 3'h0}, "rx command");
         check(rx_overflow, 1'h0, "rx overflow");
         @(negedge clk_sys);
      end
      rx_ready = 1'h0;
   endtask
   // ***************
   // main sequence
   // ***************
   initial begin
      void'($urandom(32'h759A32DB));
      {reset_n, req_valid, rx_ready, want_bus, go, rand_ok} = '0;
      {power_on_reset_n, ok_n, burst} = 5'h18;
      {req_addr_data, req_command} = '0;
      repeat (8) @(negedge clk_sys);
      reset_n = 1'h1;
      rand_ok = 1'h1;
      for (int i = 0; i < 8; i++) send($urandom, {1'h0, `SBO_CMD_WRITE});
      rand_ok = 1'h0;
      ok_n = 1'h1;
      check(issues, 8, "issue count");
      {want_bus, go, burst} = 5'h1A;
      @(negedge clk_sys);
      go = 1'h0;
      while (processor_owns_bus_n !== 1'h1) @(negedge clk_sys);
      check(shared_addr_data_bus_oe, 1'h0, "float on release");
      repeat (8) @(negedge clk_sys);
      check(rx_valid, 1'h1, "buffer holds words");
      drain(2);
      want_bus = 1'h0;
      repeat (6) @(negedge clk_sys);
      check(processor_owns_bus_n, 1'h0, "reclaim");
      {ok_n, go, burst} = 5'h0B;
      @(negedge clk_sys);
      go = 1'h0;
      send(32'h0000_0040, {1'h0, `SBO_CMD_READ});
      check(read_pending, 1'h1, "read pending");
      want_bus = 1'h1;
      drain(3);
      repeat (6) @(negedge clk_sys);
      check(processor_owns_bus_n, 1'h1, "agent keeps bus");
      check(read_pending, 1'h0, "read done");
      want_bus = 1'h0;
      repeat (6) @(negedge clk_sys);
      check(processor_owns_bus_n, 1'h0, "master again");
      {want_bus, ok_n} = 2'h3;
      while (processor_owns_bus_n !== 1'h1) @(negedge clk_sys);
      power_on_reset_n = 1'h0;
      @(negedge clk_sys);
      check(processor_owns_bus_n, 1'h0, "owner at reset");
      check(shared_addr_data_bus_oe, 1'h1, "drive at reset");
      {want_bus, power_on_reset_n} = 2'h1;
      repeat (4) @(negedge clk_sys);
      finish_test;
   end
   initial begin
      #2000000;
      fails++;
      finish_test;
   end
endmodule // tb_sbo_arbiter
`default_nettype wire
